// ---- rtl/swrs_map.svh ----
/*
  Constant map for the single-wire ROM search and scratchpad block.
  Assumes inclusion by bare name from both end modules and the bench files.
*/
`ifndef SWRS_MAP_SVH
`define SWRS_MAP_SVH
// ==========================================================
// Command bytes
`define SWRS_CMD_SKIP 8'hcc
`define SWRS_CMD_SEARCH 8'hf0
`define SWRS_CMD_WRSP 8'h4e
// ==========================================================
// Geometry
`define SWRS_ROM_BITS 64
`define SWRS_PAGE_MAX 8'h07
`define SWRS_PAGE_BYTES 4'h8
// ==========================================================
// Timing: reset low time in ns at a 4 ns clock
`define SWRS_RESET_NS 480000
`define SWRS_CLK_NS 4
`define SWRS_RESET_CYC ((`SWRS_RESET_NS + `SWRS_CLK_NS - 1) / `SWRS_CLK_NS)
`endif

// ---- rtl/swrs_pkg.sv ----
/*
  Types shared by both ends of the single-wire ROM search link.
  Assumes swrs_map.svh holds every number except the slot kind codes defined here.
*/
package swrs_pkg;
	// Slot kinds that the master may run on the line
	typedef enum logic [3:0] {
		SWRS_SLOT_RESET = 4'h1,
		SWRS_SLOT_WR0 = 4'h2,
		SWRS_SLOT_WR1 = 4'h4,
		SWRS_SLOT_RD = 4'h8
	} swrs_slot_type;
endpackage

// ---- rtl/swrs_link_if.sv ----
/*
  Single-wire link carrier: slot-level abstraction of the open-drain line.
  Assumes the bench resolves the wired-AND level from the pull enables.
*/
`timescale 1ns/1ps
`default_nettype none
interface swrs_link_if;
	logic slot_vld; // Master starts a slot, one-cycle pulse
	logic [3:0] slot_kind; // Slot kind, swrs_pkg::swrs_slot_type code
	logic mst_pull_oe; // Master pulls line low
	logic dev_pull_oe; // Device pulls line low
	logic line_in; // Resolved line level seen by both
	modport master (output slot_vld, output slot_kind, output mst_pull_oe, input line_in);
	modport device (input slot_vld, input slot_kind, output dev_pull_oe, input line_in);
endinterface
`default_nettype wire

// ---- rtl/swrs_device.sv ----
/*
  Device end: reset/presence, Skip ROM, Search ROM arbitration and
  the start of Write Scratchpad, driven by slot events on the link.
  Assumes the master produces slot events and the bench resolves the line.
*/
// Contract
// [RL1] Skip command goes straight to memory commands
// [RL2] Send zero by pulling, one by releasing
// [RL3] Search command starts arbitration over ROM code
// [RL4] Per bit: read, complement read, direction write
// [RL5] First read slot drives ROM bit
// [RL6] Second read slot drives inverted ROM bit
// [RL7] Mismatching direction deselects until next reset
// [RL8] Matching direction keeps device, next bit
// [RL9] Master decodes the two read bits
// [RL10] ROM presented least significant bit first
// [RL11] Each pass starts with reset and presence
// [RL12] Master repeats passes to find all
// [RL13] Page byte 00h-07h follows scratchpad command
// [RL14] Writes start at byte zero, sequential, eight
// [RL15] Reset abandons scratchpad write
// [RL16] Scratchpad write command byte is 4Eh
// [RL17] Unselected device ignores traffic until reset
// [RL18] Line low over 480 us resets device
// [RL19] ROM is family, serial, CRC in order
// [RL20] Surviving full search accepts memory command
// [RL21] Bytes beyond eighth ignored, no wrap
`timescale 1ns/1ps
`default_nettype none
`include "swrs_map.svh"
module swrs_device #(
	parameter logic [7:0] FAMILY = 8'h5a, // Arbitrary value
	parameter logic [47:0] SERIAL = 48'h0123456789ab, // Arbitrary value
	parameter logic [7:0] CRC = 8'h3c, // Arbitrary value
	parameter int RESET_CYC = `SWRS_RESET_CYC
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	swrs_link_if.device LINK,
	output logic WR_VLD,
	output logic [2:0] WR_PAGE,
	output logic [2:0] WR_ADDR,
	output logic [7:0] WR_DATA,
	output logic SEL
);
	// ==========================================================
	// Checks and constants
	// Fewer cycles could not tell a long low from a slot's own pull
	if (RESET_CYC < 2) begin : g_reset_cyc_check
		$error("RESET_CYC too small");
	end
	localparam logic [63:0] ROM = {CRC, SERIAL, FAMILY}; // RL19
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01, // Waiting for reset
		ST_ROMCMD = 7'h02, // Collecting ROM command
		ST_SEARCH = 7'h04, // Arbitration
		ST_MEMCMD = 7'h08, // Collecting memory command
		ST_PAGE = 7'h10, // Collecting page byte
		ST_DATA = 7'h20, // Scratchpad data bytes
		ST_DEAD = 7'h40 // Deselected, waits for reset
	} swrs_dst_type;
	// ==========================================================
	// State
	swrs_dst_type st_q, st_d;
	logic [7:0] sh_q, sh_d; // Byte shifter, LSB first
	logic [2:0] bc_q, bc_d; // Bit counter in byte
	logic [5:0] pos_q, pos_d; // Search bit position
	logic [1:0] ph_q, ph_d; // Search slot phase
	logic [2:0] pg_q, pg_d; // Selected page
	logic [3:0] ad_q, ad_d; // Byte address, saturates at 8
	logic pull_q, pull_d; // Line pull for presence or current read slot
	logic [31:0] low_q, low_d; // Low-time counter
	logic wv_q, wv_d;
	logic [7:0] wd_q, wd_d;
	logic [2:0] wa_q, wa_d; // Address of the byte just written
	logic sel_q, sel_d; // Still addressed by the master
	logic is_wr, bitv, rd, rst_slot, long_low;
	logic [7:0] byte_nx;
	always_comb begin
		rd = LINK.slot_vld && LINK.slot_kind == swrs_pkg::SWRS_SLOT_RD;
		is_wr = LINK.slot_vld && (LINK.slot_kind == swrs_pkg::SWRS_SLOT_WR0 ||
			LINK.slot_kind == swrs_pkg::SWRS_SLOT_WR1);
		bitv = LINK.slot_kind == swrs_pkg::SWRS_SLOT_WR1;
		rst_slot = LINK.slot_vld && LINK.slot_kind == swrs_pkg::SWRS_SLOT_RESET;
		long_low = low_q >= 32'(RESET_CYC); // RL18
		byte_nx = {bitv, sh_q[7:1]};
	end
	// ==========================================================
	// Next-state logic
	always_comb begin
		st_d = st_q;
		sh_d = sh_q;
		bc_d = bc_q;
		pos_d = pos_q;
		ph_d = ph_q;
		pg_d = pg_q;
		ad_d = ad_q;
		pull_d = 1'b0;
		wv_d = 1'b0;
		wd_d = wd_q;
		wa_d = wa_q;
		low_d = LINK.line_in ? 32'h0 : (long_low ? low_q : low_q + 32'h1);
		if (rst_slot || long_low) begin
			// Reset and presence restart every command; abandons writes
			st_d = ST_ROMCMD; // RL11 RL15 RL18
			bc_d = 3'h0;
			ph_d = 2'h0;
			pos_d = 6'h0;
			ad_d = 4'h0;
			// Presence answers a reset slot only; a held-low line has no slot to answer
			pull_d = rst_slot; // RL11
		end else begin
			case (st_q)
				ST_ROMCMD, ST_MEMCMD, ST_PAGE, ST_DATA: begin
					if (is_wr) begin
						sh_d = byte_nx;
						bc_d = bc_q + 3'h1;
						if (bc_q == 3'h7) begin
							case (st_q)
								ST_ROMCMD: begin
									if (byte_nx == `SWRS_CMD_SKIP) begin
										st_d = ST_MEMCMD; // RL1
									end else if (byte_nx == `SWRS_CMD_SEARCH) begin
										st_d = ST_SEARCH; // RL3
									end else begin
										st_d = ST_DEAD;
									end
								end
								ST_MEMCMD: begin
									// Only the scratchpad write is handled here
									st_d = (byte_nx == `SWRS_CMD_WRSP) ? ST_PAGE : ST_DEAD; // RL16
								end
								ST_PAGE: begin
									// Out-of-range page is refused
									st_d = (byte_nx <= `SWRS_PAGE_MAX) ? ST_DATA : ST_DEAD; // RL13
									pg_d = byte_nx[2:0];
									ad_d = 4'h0; // RL14
								end
								default: begin
									if (ad_q < `SWRS_PAGE_BYTES) begin // RL21
										wv_d = 1'b1; // RL14
										wd_d = byte_nx;
										wa_d = ad_q[2:0];
										ad_d = ad_q + 4'h1;
									end
								end
							endcase
						end
					end
				end
				ST_SEARCH: begin
					if (rd && ph_q == 2'h0) begin
						pull_d = ~ROM[pos_q]; // RL5 RL10 RL2
						ph_d = 2'h1; // RL4
					end else if (rd && ph_q == 2'h1) begin
						pull_d = ROM[pos_q]; // RL6 RL2
						ph_d = 2'h2;
					end else if (is_wr && ph_q == 2'h2) begin
						ph_d = 2'h0;
						if (bitv != ROM[pos_q]) begin
							st_d = ST_DEAD; // RL7
						end else if (pos_q == 6'(`SWRS_ROM_BITS - 1)) begin
							st_d = ST_MEMCMD; // RL20
							bc_d = 3'h0;
						end else begin
							pos_d = pos_q + 6'h1; // RL8
						end
					end
				end
				ST_DEAD: begin
					st_d = ST_DEAD; // RL17
				end
				default: begin
					st_d = ST_IDLE;
				end
			endcase
		end
		// Registered so that SEL changes on the same edge as the state
		sel_d = (st_d != ST_DEAD) && (st_d != ST_IDLE);
	end
	// ==========================================================
	// Registers, frozen while CE is low
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_q <= ST_IDLE;
			sh_q <= 8'h00;
			bc_q <= 3'h0;
			pos_q <= 6'h00;
			ph_q <= 2'h0;
			pg_q <= 3'h0;
			ad_q <= 4'h0;
			pull_q <= 1'b0;
			low_q <= 32'h0;
			wv_q <= 1'b0;
			wd_q <= 8'h00;
			wa_q <= 3'h0;
			sel_q <= 1'b0;
		end else if (CE) begin
			st_q <= st_d;
			sh_q <= sh_d;
			bc_q <= bc_d;
			pos_q <= pos_d;
			ph_q <= ph_d;
			pg_q <= pg_d;
			ad_q <= ad_d;
			pull_q <= pull_d;
			low_q <= low_d;
			wv_q <= wv_d;
			wd_q <= wd_d;
			wa_q <= wa_d;
			sel_q <= sel_d;
		end
	end
	// ==========================================================
	// Outputs from flip-flops
	assign LINK.dev_pull_oe = pull_q; // RL2
	assign WR_VLD = wv_q;
	assign WR_DATA = wd_q;
	assign WR_PAGE = pg_q;
	assign WR_ADDR = wa_q;
	assign SEL = sel_q;
endmodule
`default_nettype wire

// ---- rtl/swrs_master.sv ----
/*
  Master end: turns user slot requests into link slot events and
  returns the sampled line level two cycles after each read or reset slot.
  Assumes the user paces requests; the decision logic of a search
  (RL9, RL12) lives in the user above this end.
*/
`timescale 1ns/1ps
`default_nettype none
`include "swrs_map.svh"
module swrs_master (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	swrs_link_if.master LINK,
	input wire logic REQ,
	input wire logic [3:0] KIND,
	output logic BUSY,
	output logic RD_VLD,
	output logic RD_BIT
);
	// ==========================================================
	// State: slot issue then sample
	logic v_q, v_d; // Slot pulse on link
	logic [3:0] k_q, k_d; // Slot kind on link
	logic s_q, s_d; // Sample pending
	logic rv_q, rv_d;
	logic rb_q, rb_d;
	logic bz_q, bz_d; // Slot or sample in flight
	logic mp_q, mp_d; // Master pulls the line
	always_comb begin
		v_d = REQ && !v_q;
		k_d = REQ && !v_q ? KIND : k_q;
		// A reset slot is sampled like a read, to see the presence pulse
		s_d = v_q && (k_q == swrs_pkg::SWRS_SLOT_RD ||
			k_q == swrs_pkg::SWRS_SLOT_RESET); // RL11
		bz_d = v_d || s_d;
		mp_d = v_d && (k_d == swrs_pkg::SWRS_SLOT_WR0 ||
			k_d == swrs_pkg::SWRS_SLOT_RESET);
		rv_d = s_q;
		rb_d = s_q ? LINK.line_in : rb_q; // RL9 decoded by the user
	end
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			v_q <= 1'b0;
			k_q <= 4'h0;
			s_q <= 1'b0;
			rv_q <= 1'b0;
			rb_q <= 1'b1;
			bz_q <= 1'b0;
			mp_q <= 1'b0;
		end else if (CE) begin
			v_q <= v_d;
			k_q <= k_d;
			s_q <= s_d;
			rv_q <= rv_d;
			rb_q <= rb_d;
			bz_q <= bz_d;
			mp_q <= mp_d;
		end
	end
	// ==========================================================
	// Link drive: a write-zero slot pulls the line for one cycle
	assign LINK.slot_vld = v_q; // RL4 RL11
	assign LINK.slot_kind = k_q;
	assign LINK.mst_pull_oe = mp_q;
	assign BUSY = bz_q;
	assign RD_VLD = rv_q;
	assign RD_BIT = rb_q;
endmodule
`default_nettype wire

// ---- bench/swrs_link_sva.sv ----
/*
  Checker for the single-wire link between the master and device A.
  Assumes it is instantiated beside that link and given device A's ROM code.
*/
`timescale 1ns/1ps
`default_nettype none
`include "swrs_map.svh"
module swrs_link_sva #(
	parameter logic [63:0] ROM = 64'h0
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic slot_vld,
	input wire logic [3:0] slot_kind,
	input wire logic mst_pull_oe,
	input wire logic dev_pull_oe
);
	// ==========================================================
	// Search tracking
	localparam logic [3:0] K_RS = swrs_pkg::SWRS_SLOT_RESET;
	localparam logic [3:0] K_W0 = swrs_pkg::SWRS_SLOT_WR0;
	localparam logic [3:0] K_W1 = swrs_pkg::SWRS_SLOT_WR1;
	localparam logic [3:0] K_RD = swrs_pkg::SWRS_SLOT_RD;
	logic rd_ans_q, srch_q, gone_q, p1_q; // Answer cycle, searching, dropped, first pull
	logic [3:0] wc_q; // Command bits seen
	logic [7:0] cmd_q; // Command byte, LSB first
	logic [1:0] ph_q; // Slot within a search triple
	logic [6:0] bn_q; // ROM bit position
	wire logic srch = srch_q && bn_q != 7'd64;
	wire logic w1 = slot_kind == K_W1;
	// Mirrors the device's view; a reset slot clears it just as it clears the device
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			{rd_ans_q, srch_q, gone_q, p1_q, wc_q, cmd_q, ph_q, bn_q} <= '0;
		end else begin
			rd_ans_q <= slot_vld && slot_kind == K_RD;
			if (rd_ans_q && ph_q == 2'h1) begin
				p1_q <= dev_pull_oe;
			end
			if (slot_vld && slot_kind == K_RS) begin
				{srch_q, gone_q, wc_q, ph_q, bn_q} <= '0;
			end else if (slot_vld && srch) begin
				ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
				if (ph_q == 2'h2) begin
					bn_q <= bn_q + 7'h1;
					gone_q <= gone_q | (p1_q == w1);
				end
			end else if (slot_vld && wc_q != 4'h8 && slot_kind != K_RD) begin
				cmd_q <= {w1, cmd_q[7:1]};
				wc_q <= wc_q + 4'h1;
				srch_q <= wc_q == 4'h7 && {w1, cmd_q[7:1]} == `SWRS_CMD_SEARCH;
			end
		end
	end
	// ==========================================================
	// Properties
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	sequence rd_slot;
		slot_vld && slot_kind == K_RD;
	endsequence
	sequence wr_slot;
		slot_vld && (slot_kind == K_W0 || w1);
	endsequence
	slot_pulse_a: assert property (slot_vld |=> !slot_vld)
		else $error("slot strobe longer than one cycle");
	slot_kind_a: assert property (slot_vld |-> $onehot(slot_kind))
		else $error("slot kind not one-hot");
	write_quiet_a: assert property (wr_slot |=> !dev_pull_oe)
		else $error("device pulled in a write slot");
	read_release_a: assert property (rd_slot |=> !mst_pull_oe)
		else $error("master holds line in read answer");
	pull_stands_a: assert property (dev_pull_oe |=> !dev_pull_oe)
		else $error("device pull longer than one cycle");
	rom_bit_a: assert property (srch && ph_q == 2'h0 && !gone_q ##0 rd_slot |=> dev_pull_oe == !ROM[bn_q])
		else $error("wrong ROM bit in first read");
	comp_bit_a: assert property (srch && ph_q == 2'h1 && !gone_q ##0 rd_slot |=> dev_pull_oe != p1_q)
		else $error("second read not the complement");
	dropped_quiet_a: assert property (gone_q |-> !dev_pull_oe)
		else $error("deselected device pulled the line");
	presence_a: assert property (slot_vld && slot_kind == K_RS |=> dev_pull_oe)
		else $error("no presence pulse after reset slot");
endmodule
`default_nettype wire

// ---- bench/single_wire_rom_search_scratchpad_test.sv ----
/*
  Bench: master and two devices on one resolved line, plus the link checker.
  Assumes the design files and swrs_map.svh are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "swrs_map.svh"
module single_wire_rom_search_scratchpad_test;
	// ==========================================================
	// Setup
	localparam logic [47:0] SER = 48'h0123456789ab; // Arbitrary value
	localparam logic [7:0] CRC = 8'h3c; // Arbitrary value
	localparam logic [63:0] ROM_A = {CRC, SER, 8'h5a}; // Arbitrary family
	localparam logic [63:0] ROM_B = {CRC, SER, 8'h5b}; // Differs at bit 0
	localparam logic [3:0] K_RS = swrs_pkg::SWRS_SLOT_RESET;
	localparam logic [3:0] K_W0 = swrs_pkg::SWRS_SLOT_WR0;
	localparam logic [3:0] K_W1 = swrs_pkg::SWRS_SLOT_WR1;
	localparam logic [3:0] K_RD = swrs_pkg::SWRS_SLOT_RD;
	logic clk, rst_n, ce, req, tb_pull, rd_vld, rd_bit, sel_a, sel_b, wr_vld, busy;
	logic [3:0] kind;
	logic [2:0] wr_page, wr_addr;
	logic [7:0] wr_data;
	int n_errors, check_count;
	logic [13:0] got[$]; // Writes seen at device A
	swrs_link_if link_a();
	swrs_link_if link_b();
	// Wired-AND of every puller, the bench included
	wire logic line = !(link_a.mst_pull_oe | link_a.dev_pull_oe | link_b.dev_pull_oe | tb_pull);
	assign link_a.line_in = line;
	assign link_b.line_in = line;
	assign link_b.slot_vld = link_a.slot_vld;
	assign link_b.slot_kind = link_a.slot_kind;
	assign link_b.mst_pull_oe = link_a.mst_pull_oe;
	swrs_master swrs_master_i (.CLK(clk), .RST_N(rst_n), .CE(ce), .LINK(link_a), .REQ(req),
		.KIND(kind), .BUSY(busy), .RD_VLD(rd_vld), .RD_BIT(rd_bit));
	swrs_device #(.FAMILY(8'h5a), .SERIAL(SER), .CRC(CRC), .RESET_CYC(16)) swrs_device_i (
		.CLK(clk), .RST_N(rst_n), .CE(ce), .LINK(link_a), .WR_VLD(wr_vld),
		.WR_PAGE(wr_page), .WR_ADDR(wr_addr), .WR_DATA(wr_data), .SEL(sel_a));
	swrs_device #(.FAMILY(8'h5b), .SERIAL(SER), .CRC(CRC), .RESET_CYC(16)) swrs_device_b_i (
		.CLK(clk), .RST_N(rst_n), .CE(ce), .LINK(link_b), .WR_VLD(),
		.WR_PAGE(), .WR_ADDR(), .WR_DATA(), .SEL(sel_b));
	swrs_link_sva #(.ROM(ROM_A)) swrs_link_sva_i (.CLK(clk), .RST_N(rst_n),
		.slot_vld(link_a.slot_vld), .slot_kind(link_a.slot_kind),
		.mst_pull_oe(link_a.mst_pull_oe), .dev_pull_oe(link_a.dev_pull_oe));
	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Record each scratchpad write of device A
	always @(posedge clk) begin
		if (wr_vld === 1'b1) begin
			got.push_back({wr_page, wr_addr, wr_data});
		end
	end
	// ==========================================================
	// Tasks
	task automatic check(string what, logic [63:0] exp, logic [63:0] seen);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	// One slot; a read or reset waits for the sampled bit, bounded
	task automatic slot(logic [3:0] k, output logic b);
		int n;
		logic smp;
		smp = (k == K_RD || k == K_RS);
		@(posedge clk);
		req <= 1'b1;
		kind <= k;
		@(posedge clk);
		req <= 1'b0;
		b = 1'b1;
		for (n = 0; n < 8; n++) begin
			@(posedge clk);
			#1;
			if (!smp && n == 1) break;
			if (smp && rd_vld === 1'b1) break;
		end
		if (n == 8) check("read done", 1, 0);
		check("busy after slot", 1'b0, busy);
		b = rd_bit;
	endtask
	task automatic wbyte(logic [7:0] v);
		logic b;
		for (int i = 0; i < 8; i++) slot(v[i] ? K_W1 : K_W0, b);
	endtask
	task automatic init(logic [7:0] rom_cmd);
		logic b;
		slot(K_RS, b);
		check("presence", 1'b0, b);
		repeat (4) @(posedge clk);
		wbyte(rom_cmd);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_write();
		init(`SWRS_CMD_SKIP);
		check("skip select", 2'b11, {sel_a, sel_b});
		got.delete();
		wbyte(`SWRS_CMD_WRSP);
		wbyte(8'h05);
		// Line held low with the clock gated must not count as a long low
		@(posedge clk);
		ce <= 1'b0;
		tb_pull <= 1'b1;
		repeat (20) @(posedge clk);
		tb_pull <= 1'b0;
		ce <= 1'b1;
		for (int i = 0; i < 9; i++) wbyte(8'h10 + 8'(i));
		check("write count", 8, 64'(got.size()));
		for (int i = 0; i < 8; i++) check("write entry", {3'h5, 3'(i), 8'h10 + 8'(i)}, got[i]);
	endtask
	// Abandon by reset slot, long low line, and a bad page
	task automatic t_abort();
		got.delete();
		init(`SWRS_CMD_SKIP);
		wbyte(`SWRS_CMD_WRSP);
		wbyte(8'h02);
		wbyte(8'h77);
		init(8'h88);
		check("abort by reset", {1'b0, 8'd1, 14'h1077}, {sel_a, 8'(got.size()), got[0]});
		init(`SWRS_CMD_SKIP);
		wbyte(`SWRS_CMD_WRSP);
		@(posedge clk);
		tb_pull <= 1'b1;
		repeat (20) @(posedge clk);
		tb_pull <= 1'b0;
		wbyte(8'h01);
		wbyte(8'h99);
		check("long low reset", {1'b0, 8'd1}, {sel_a, 8'(got.size())});
		init(`SWRS_CMD_SKIP);
		wbyte(`SWRS_CMD_WRSP);
		wbyte(8'h08);
		wbyte(8'h11);
		check("bad page", {1'b0, 8'd1}, {sel_a, 8'(got.size())});
	endtask
	// One search pass steered along rom, then a write to the survivor
	task automatic t_search(logic [63:0] rom, logic [1:0] exp_sel);
		logic r1, r2;
		init(`SWRS_CMD_SEARCH);
		for (int i = 0; i < 64; i++) begin
			slot(K_RD, r1);
			slot(K_RD, r2);
			check("search bits", (i == 0) ? 2'b00 : {rom[i], !rom[i]}, {r1, r2});
			slot(rom[i] ? K_W1 : K_W0, r1);
		end
		check("survivors", exp_sel, {sel_a, sel_b});
		got.delete();
		wbyte(`SWRS_CMD_WRSP);
		wbyte(8'h03);
		wbyte(8'ha5);
		check("write after search", exp_sel[1], 64'(got.size()));
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ==========================================================
	// Main sequence and watchdog
	initial begin
		{rst_n, req, tb_pull, kind, n_errors, check_count} = '0;
		ce = 1'b1;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_write();
		t_abort();
		t_search(ROM_A, 2'b10);
		t_search(ROM_B, 2'b01);
		final_report();
	end
	initial begin
		repeat (30000) @(posedge clk);
		n_errors++;
		final_report();
	end
endmodule
`default_nettype wire
